// *** hw/ptc_timestamp_control.sv ***
// Overview of operation
// - Master bit picks master-relevant messages, else slave-relevant ones.
// - Event-only bit restricts snapshots to event messages; clear also admits general ones.
// - IPv4 and IPv6 enable bits allow snapshots for PTP in those frames.
// - Raw-Ethernet bit adds PTP carried directly in Ethernet frames.
// - Version bit parses snooped packets as version 2, else version 1.
// - Digital rollover wraps sub-seconds after 0x3B9A_C9FF and bumps seconds.
// - Binary mode wraps sub-seconds after 0x7FFF_FFFF.
// - All-frames bit snapshots every received frame.
// - Addend command loads addend into fine logic, then clears itself.
// - Trigger enable raises pulse when time passes target, then clears.
// - Update command adds or subtracts update values; high word untouched.
// - Initialize command overwrites time, including high word; self-clears.
// - Correction bit selects fine when set, coarse when clear.
// - Stamping enable off stops snapshots and halts the time generator.
// - Select 00 picks the end-to-end sets per event and master bits.
// - Select 01 adds peer-delay; 10 gives SYNC, Delay_Req; 11 peer requests and responses.
// - Coarse adds step every reference tick; fine only on accumulator carry.
// - Eight-bit step value is added to sub-seconds on each advance.
// - Two-bit packet select works with master and event bits.
//
// The address-and-strobe port and the register addresses were decided locally.
module ptc_timestamp_control
  import ptc_pkg::*;
#(
  parameter int REF_DIV = PTC_REF_DIV
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // Register port
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Values held by neighbouring registers
  input  wire logic [31:0] addend_value_i,
  input  wire logic [31:0] target_sec_i,
  input  wire logic [30:0] target_subsec_i,
  input  wire logic [15:0] update_hi_i,
  input  wire logic [31:0] update_sec_i,
  input  wire logic [30:0] update_subsec_i,
  input  wire logic        update_subtract_i,
  // Frame summary from the datapath
  input  wire logic        frame_end_i,
  input  wire logic        frame_ptp_i,
  input  wire logic        frame_ipv4_i,
  input  wire logic        frame_ipv6_i,
  input  wire logic        frame_raw_i,
  input  wire logic [3:0]  frame_msg_i,
  // System time and events
  output logic      [15:0] sys_time_hi_o,
  output logic      [31:0] sys_time_sec_o,
  output logic      [30:0] sys_time_subsec_o,
  output logic             snap_take_o,
  output logic             target_reached_o,
  output logic             stamping_enable_o
);

  typedef struct packed {
    logic [1:0]  packet_type_select;
    logic        master_msg_select;
    logic        event_msg_only;
    logic        ipv4_snap_enable;
    logic        ipv6_snap_enable;
    logic        raw_ether_snap_enable;
    logic        ptp_v2_format_select;
    logic        digital_rollover_select;
    logic        all_frames_snap_enable;
    logic        addend_update_cmd;
    logic        target_trigger_enable;
    logic        time_update_cmd;
    logic        time_initialize_cmd;
    logic        fine_coarse_select;
    logic        stamping_enable;
    logic [7:0]  subsecond_step_value;
    logic [31:0] addend;
    logic [31:0] acc;
    logic [15:0] hi;
    logic [31:0] sec;
    logic [30:0] subsec;
    logic        target_hit;
    logic [31:0] rdata;
  } ptc_state_type;

  ptc_state_type s;
  ptc_state_type next_s;

  logic ref_tick;

  function automatic logic [31:0] ctrl_word(input ptc_state_type st);
    logic [31:0] w;
    w = '0;
    w[PTC_B_PKT_SEL +: 2] = st.packet_type_select;
    w[PTC_B_MASTER]  = st.master_msg_select;
    w[PTC_B_EVENT]   = st.event_msg_only;
    w[PTC_B_IPV4]    = st.ipv4_snap_enable;
    w[PTC_B_IPV6]    = st.ipv6_snap_enable;
    w[PTC_B_RAW]     = st.raw_ether_snap_enable;
    w[PTC_B_V2]      = st.ptp_v2_format_select;
    w[PTC_B_DIGITAL] = st.digital_rollover_select;
    w[PTC_B_ALL]     = st.all_frames_snap_enable;
    w[PTC_B_ADDEND]  = st.addend_update_cmd;
    w[PTC_B_TRIGGER] = st.target_trigger_enable;
    w[PTC_B_UPDATE]  = st.time_update_cmd;
    w[PTC_B_INIT]    = st.time_initialize_cmd;
    w[PTC_B_FINE]    = st.fine_coarse_select;
    w[PTC_B_STAMP]   = st.stamping_enable;
    return w;
  endfunction

  ptc_tick_div #(
    .DIV (REF_DIV)
  ) u_div (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_o    (ref_tick)
  );

  ptc_snap_filter u_filter (
    .sys_clk_i                (sys_clk_i),
    .sys_rst_i                (sys_rst_i),
    .stamping_enable_i        (s.stamping_enable),
    .all_frames_snap_enable_i (s.all_frames_snap_enable),
    .ipv4_snap_enable_i       (s.ipv4_snap_enable),
    .ipv6_snap_enable_i       (s.ipv6_snap_enable),
    .raw_ether_snap_enable_i  (s.raw_ether_snap_enable),
    .ptp_v2_format_select_i   (s.ptp_v2_format_select),
    .master_msg_select_i      (s.master_msg_select),
    .event_msg_only_i         (s.event_msg_only),
    .packet_type_select_i     (s.packet_type_select),
    .frame_end_i              (frame_end_i),
    .frame_ptp_i              (frame_ptp_i),
    .frame_ipv4_i             (frame_ipv4_i),
    .frame_ipv6_i             (frame_ipv6_i),
    .frame_raw_i              (frame_raw_i),
    .frame_msg_i              (frame_msg_i),
    .snap_o                   (snap_take_o)
  );

  logic [32:0] acc_sum;
  logic        advance;
  logic [30:0] max_sub;
  logic [31:0] wrap;
  logic [31:0] step_sum;
  logic [31:0] upd_sum;
  logic        time_later;

  always_comb begin
    next_s = s;
    next_s.target_hit = 1'b0;
    next_s.rdata = '0;
    advance = 1'b0;
    acc_sum = {1'b0, s.acc} + {1'b0, s.addend};
    max_sub = s.digital_rollover_select ? PTC_DIGITAL_MAX : PTC_BINARY_MAX;
    wrap = {1'b0, max_sub} + 32'h1;
    step_sum = {1'b0, s.subsec} + {24'h0, s.subsecond_step_value};
    upd_sum = '0;
    time_later = (s.sec > target_sec_i) ||
                 ((s.sec == target_sec_i) && (s.subsec > target_subsec_i));

    // Generator runs only while stamping is on
    if (ref_tick && s.stamping_enable) begin
      if (s.fine_coarse_select) begin
        next_s.acc = acc_sum[31:0];
        advance = acc_sum[32];
      end else begin
        advance = 1'b1;
      end
    end

    if (advance) begin
      if (step_sum >= wrap) begin
        next_s.subsec = 31'(step_sum - wrap);
        next_s.sec = s.sec + 32'h1;
      end else begin
        next_s.subsec = step_sum[30:0];
      end
    end

    // Update replaces the tick in the cycle it applies; high word is left alone
    if (s.time_update_cmd) begin
      if (update_subtract_i) begin
        if (update_subsec_i > s.subsec) begin
          upd_sum = {1'b0, s.subsec} + wrap - {1'b0, update_subsec_i};
          next_s.subsec = upd_sum[30:0];
          next_s.sec = s.sec - update_sec_i - 32'h1;
        end else begin
          next_s.subsec = s.subsec - update_subsec_i;
          next_s.sec = s.sec - update_sec_i;
        end
      end else begin
        upd_sum = {1'b0, s.subsec} + {1'b0, update_subsec_i};
        if (upd_sum >= wrap) begin
          next_s.subsec = 31'(upd_sum - wrap);
          next_s.sec = s.sec + update_sec_i + 32'h1;
        end else begin
          next_s.subsec = upd_sum[30:0];
          next_s.sec = s.sec + update_sec_i;
        end
      end
      next_s.time_update_cmd = 1'b0;
    end

    // Initialize wins over update if both were requested
    if (s.time_initialize_cmd) begin
      next_s.hi = update_hi_i;
      next_s.sec = update_sec_i;
      next_s.subsec = update_subsec_i;
      next_s.acc = '0;
      next_s.time_initialize_cmd = 1'b0;
      next_s.time_update_cmd = 1'b0;
    end

    if (s.addend_update_cmd) begin
      next_s.addend = addend_value_i;
      next_s.addend_update_cmd = 1'b0;
    end

    // Compared on the running time, so the pulse follows the crossing by one cycle
    if (s.target_trigger_enable && s.stamping_enable && time_later) begin
      next_s.target_hit = 1'b1;
      next_s.target_trigger_enable = 1'b0;
    end

    // A software write in the same cycle overrides any self-clear above
    if (reg_wr_i) begin
      if (reg_addr_i == PTC_CTRL_OFFSET) begin
        next_s.packet_type_select      = reg_wdata_i[PTC_B_PKT_SEL +: 2];
        next_s.master_msg_select       = reg_wdata_i[PTC_B_MASTER];
        next_s.event_msg_only          = reg_wdata_i[PTC_B_EVENT];
        next_s.ipv4_snap_enable        = reg_wdata_i[PTC_B_IPV4];
        next_s.ipv6_snap_enable        = reg_wdata_i[PTC_B_IPV6];
        next_s.raw_ether_snap_enable   = reg_wdata_i[PTC_B_RAW];
        next_s.ptp_v2_format_select    = reg_wdata_i[PTC_B_V2];
        next_s.digital_rollover_select = reg_wdata_i[PTC_B_DIGITAL];
        next_s.all_frames_snap_enable  = reg_wdata_i[PTC_B_ALL];
        next_s.addend_update_cmd       = reg_wdata_i[PTC_B_ADDEND] | next_s.addend_update_cmd;
        next_s.target_trigger_enable   = reg_wdata_i[PTC_B_TRIGGER];
        next_s.time_update_cmd         = reg_wdata_i[PTC_B_UPDATE] | next_s.time_update_cmd;
        next_s.time_initialize_cmd     = reg_wdata_i[PTC_B_INIT] | next_s.time_initialize_cmd;
        next_s.fine_coarse_select      = reg_wdata_i[PTC_B_FINE];
        next_s.stamping_enable         = reg_wdata_i[PTC_B_STAMP];
      end else if (reg_addr_i == PTC_STEP_OFFSET) begin
        next_s.subsecond_step_value = reg_wdata_i[PTC_STEP_LSB +: PTC_STEP_W];
      end
    end

    // Unmapped reads return zero
    if (reg_rd_i) begin
      if (reg_addr_i == PTC_CTRL_OFFSET) begin
        next_s.rdata = ctrl_word(s);
      end else if (reg_addr_i == PTC_STEP_OFFSET) begin
        next_s.rdata = {24'h0, s.subsecond_step_value};
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
      s.ipv4_snap_enable <= PTC_CTRL_RESET[PTC_B_IPV4];
      s.subsecond_step_value <= PTC_STEP_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata_o       = s.rdata;
  assign sys_time_hi_o     = s.hi;
  assign sys_time_sec_o    = s.sec;
  assign sys_time_subsec_o = s.subsec;
  assign target_reached_o  = s.target_hit;
  assign stamping_enable_o = s.stamping_enable;

endmodule

// *** include/ptc_pkg.sv ***
package ptc_pkg;

  // Register map, byte addresses
  localparam logic [15:0] PTC_CTRL_OFFSET = 16'h0700;
  localparam logic [15:0] PTC_STEP_OFFSET = 16'h0704;

  // Control register field positions
  localparam int PTC_B_PKT_SEL   = 16;
  localparam int PTC_B_MASTER    = 15;
  localparam int PTC_B_EVENT     = 14;
  localparam int PTC_B_IPV4      = 13;
  localparam int PTC_B_IPV6      = 12;
  localparam int PTC_B_RAW       = 11;
  localparam int PTC_B_V2        = 10;
  localparam int PTC_B_DIGITAL   = 9;
  localparam int PTC_B_ALL       = 8;
  localparam int PTC_B_ADDEND    = 5;
  localparam int PTC_B_TRIGGER   = 4;
  localparam int PTC_B_UPDATE    = 3;
  localparam int PTC_B_INIT      = 2;
  localparam int PTC_B_FINE      = 1;
  localparam int PTC_B_STAMP     = 0;
  localparam int PTC_STEP_LSB    = 0;
  localparam int PTC_STEP_W      = 8;

  // Values after reset
  localparam logic [31:0] PTC_CTRL_RESET = 32'h0000_2000;
  localparam logic [7:0]  PTC_STEP_RESET = 8'h00;

  // Sub-second rollover limits
  localparam logic [30:0] PTC_DIGITAL_MAX = 31'h3b9a_c9ff;
  localparam logic [30:0] PTC_BINARY_MAX  = 31'h7fff_ffff;

  // Reference tick derived from the system clock
  localparam int PTC_SYS_CLK_MHZ = 250;
  localparam int PTC_REF_CLK_MHZ = 50;
  localparam int PTC_REF_DIV     = PTC_SYS_CLK_MHZ / PTC_REF_CLK_MHZ;

  // Message types in version 2 coding
  typedef enum logic [3:0] {
    PTC_MSG_SYNC    = 4'h0,
    PTC_MSG_DREQ    = 4'h1,
    PTC_MSG_PREQ    = 4'h2,
    PTC_MSG_PRESP   = 4'h3,
    PTC_MSG_FOLLOW  = 4'h8,
    PTC_MSG_DRESP   = 4'h9,
    PTC_MSG_PFOLLOW = 4'ha,
    PTC_MSG_ANNOUNCE = 4'hb,
    PTC_MSG_SIGNAL  = 4'hc,
    PTC_MSG_MANAGE  = 4'hd
  } ptc_msg_type;

  // Version 1 control field codes
  localparam logic [3:0] PTC_V1_SYNC   = 4'h0;
  localparam logic [3:0] PTC_V1_DREQ   = 4'h1;
  localparam logic [3:0] PTC_V1_FOLLOW = 4'h2;
  localparam logic [3:0] PTC_V1_DRESP  = 4'h3;

  typedef enum logic [1:0] {
    PTC_SEL_CLASSIC = 2'b00,
    PTC_SEL_PEER    = 2'b01,
    PTC_SEL_E2E     = 2'b10,
    PTC_SEL_P2P     = 2'b11
  } ptc_pkt_sel_type;

endpackage

// *** hw/ptc_tick_div.sv ***
module ptc_tick_div
  import ptc_pkg::*;
#(
  parameter int DIV = PTC_REF_DIV
) (
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  // Reference tick
  output logic      tick_o
);

  if (DIV < 1 || DIV > 65535) begin : g_bad_div
    $error("ptc_tick_div: DIV out of range");
  end

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } ptc_div_type;

  ptc_div_type s;
  ptc_div_type next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == 16'(DIV - 1)) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 16'h1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;

endmodule

// *** hw/ptc_snap_filter.sv ***
module ptc_snap_filter
  import ptc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  // Configuration
  input  wire logic       stamping_enable_i,
  input  wire logic       all_frames_snap_enable_i,
  input  wire logic       ipv4_snap_enable_i,
  input  wire logic       ipv6_snap_enable_i,
  input  wire logic       raw_ether_snap_enable_i,
  input  wire logic       ptp_v2_format_select_i,
  input  wire logic       master_msg_select_i,
  input  wire logic       event_msg_only_i,
  input  wire logic [1:0] packet_type_select_i,
  // Frame summary from the datapath
  input  wire logic       frame_end_i,
  input  wire logic       frame_ptp_i,
  input  wire logic       frame_ipv4_i,
  input  wire logic       frame_ipv6_i,
  input  wire logic       frame_raw_i,
  input  wire logic [3:0] frame_msg_i,
  // Decision
  output logic            snap_o
);

  typedef struct packed {
    logic snap;
  } ptc_flt_type;

  ptc_flt_type s;
  ptc_flt_type next_s;

  // Old control codes folded onto new types; unknown ones never match
  function automatic logic [3:0] to_v2(input logic v2, input logic [3:0] code);
    logic [3:0] r;
    r = PTC_MSG_MANAGE;
    if (v2) begin
      r = code;
    end else begin
      case (code)
        PTC_V1_SYNC:   r = PTC_MSG_SYNC;
        PTC_V1_DREQ:   r = PTC_MSG_DREQ;
        PTC_V1_FOLLOW: r = PTC_MSG_FOLLOW;
        PTC_V1_DRESP:  r = PTC_MSG_DRESP;
        default:       r = PTC_MSG_MANAGE;
      endcase
    end
    return r;
  endfunction

  function automatic logic wanted(input logic [1:0] sel, input logic mst, input logic evt,
                                  input logic [3:0] m);
    logic e2e;
    logic p2p;
    logic one;
    e2e = (m == PTC_MSG_SYNC) || (m == PTC_MSG_FOLLOW) ||
          (m == PTC_MSG_DREQ) || (m == PTC_MSG_DRESP);
    p2p = (m == PTC_MSG_PREQ) || (m == PTC_MSG_PRESP);
    one = mst ? (m == PTC_MSG_DREQ) : (m == PTC_MSG_SYNC);
    case (sel)
      PTC_SEL_CLASSIC: wanted = evt ? one : e2e;
      PTC_SEL_PEER:    wanted = evt ? (one || p2p) : (e2e || p2p || m == PTC_MSG_PFOLLOW);
      PTC_SEL_E2E:     wanted = (m == PTC_MSG_SYNC) || (m == PTC_MSG_DREQ);
      PTC_SEL_P2P:     wanted = p2p;
      default:         wanted = 1'b0;
    endcase
  endfunction

  logic [3:0] msg;
  logic       carrier_ok;

  always_comb begin
    next_s = s;
    msg = to_v2(ptp_v2_format_select_i, frame_msg_i);
    carrier_ok = (frame_ipv4_i && ipv4_snap_enable_i) ||
                 (frame_ipv6_i && ipv6_snap_enable_i) ||
                 (frame_raw_i && raw_ether_snap_enable_i);
    next_s.snap = 1'b0;
    if (frame_end_i && stamping_enable_i) begin
      next_s.snap = all_frames_snap_enable_i ||
                    (frame_ptp_i && carrier_ok &&
                     wanted(packet_type_select_i, master_msg_select_i,
                            event_msg_only_i, msg));
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign snap_o = s.snap;

endmodule

// *** testbench/ptc_timestamp_control_properties.sv ***
module ptc_timestamp_control_properties
  import ptc_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  // Register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // Target and update values
  input wire logic [31:0] target_sec_i,
  input wire logic [30:0] target_subsec_i,
  input wire logic [15:0] update_hi_i,
  input wire logic [31:0] update_sec_i,
  input wire logic [30:0] update_subsec_i,
  // Frames and time
  input wire logic        frame_end_i,
  input wire logic [15:0] sys_time_hi_o,
  input wire logic [31:0] sys_time_sec_o,
  input wire logic [30:0] sys_time_subsec_o,
  input wire logic        snap_take_o,
  input wire logic        target_reached_o,
  input wire logic        stamping_enable_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  logic ctrl_wr;
  assign ctrl_wr = reg_wr_i && (reg_addr_i == PTC_CTRL_OFFSET);

  sequence init_wr;
    ctrl_wr && reg_wdata_i[PTC_B_INIT];
  endsequence
  // Commands land up to two cycles after a write
  sequence quiet;
    !$past(reg_wr_i) && !$past(reg_wr_i, 2);
  endsequence

  chk_snap_cause: assert property (snap_take_o |-> $past(frame_end_i && stamping_enable_o))
    else $error("snapshot without frame or with stamping off");
  chk_ctrl_reserved: assert property ($past(reg_rd_i && reg_addr_i == PTC_CTRL_OFFSET)
    |-> reg_rdata_o[31:18] == 14'h0 && reg_rdata_o[7:6] == 2'h0)
    else $error("control reserved bits read nonzero");
  chk_step_reserved: assert property ($past(reg_rd_i && reg_addr_i == PTC_STEP_OFFSET)
    |-> reg_rdata_o[31:8] == 24'h0)
    else $error("step reserved bits read nonzero");
  chk_init_load: assert property (init_wr |=> ##1 (sys_time_hi_o == $past(update_hi_i)
    && sys_time_sec_o == $past(update_sec_i) && sys_time_subsec_o == $past(update_subsec_i)))
    else $error("initialize did not load update values");
  chk_hi_source: assert property ($changed(sys_time_hi_o)
    |-> $past(ctrl_wr && reg_wdata_i[PTC_B_INIT], 2))
    else $error("high word changed without initialize");
  chk_wrap_carry: assert property (quiet ##0 (sys_time_subsec_o < $past(sys_time_subsec_o))
    |-> sys_time_sec_o == $past(sys_time_sec_o) + 32'h1)
    else $error("sub-second wrap without seconds carry");
  chk_sec_only_wrap: assert property (quiet ##0 (sys_time_sec_o != $past(sys_time_sec_o))
    |-> sys_time_subsec_o < $past(sys_time_subsec_o))
    else $error("seconds moved without wrap");
  chk_step_bound: assert property (quiet ##0 (sys_time_subsec_o > $past(sys_time_subsec_o))
    |-> sys_time_subsec_o - $past(sys_time_subsec_o) <= 31'h0000_00ff)
    else $error("advance larger than eight-bit step");
  chk_time_halt: assert property (quiet ##0 (!stamping_enable_o && !$past(stamping_enable_o))
    |=> $stable(sys_time_subsec_o) && $stable(sys_time_sec_o))
    else $error("time moved while stamping off");
  chk_target_past: assert property (target_reached_o
    |-> {$past(sys_time_sec_o), $past(sys_time_subsec_o)} > {$past(target_sec_i), $past(target_subsec_i)})
    else $error("target event before target time");
  chk_target_once: assert property (target_reached_o |=> !target_reached_o)
    else $error("target event repeated");
endmodule

bind ptc_timestamp_control ptc_timestamp_control_properties ptc_timestamp_control_properties_i (
  .sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .target_sec_i, .target_subsec_i, .update_hi_i, .update_sec_i, .update_subsec_i,
  .frame_end_i, .sys_time_hi_o, .sys_time_sec_o, .sys_time_subsec_o, .snap_take_o,
  .target_reached_o, .stamping_enable_o);

// *** testbench/ptc_frame_src.sv ***
module ptc_frame_src (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  // Request: kind is {ptp, raw, ipv6, ipv4}
  input  wire logic       send_i,
  input  wire logic [3:0] kind_i,
  input  wire logic [3:0] msg_i,
  // Frame summary
  output logic            frame_end_o,
  output logic            frame_ptp_o,
  output logic            frame_ipv4_o,
  output logic            frame_ipv6_o,
  output logic            frame_raw_o,
  output logic      [3:0] frame_msg_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frame_end_o <= 1'b0;
      last <= 8'h00;
    end else begin
      frame_end_o <= send_i;
      if (send_i) begin
        last <= {kind_i, msg_i};
      end
    end
  end
  // Between frames the fields carry garbage, never the last frame
  assign {frame_ptp_o, frame_raw_o, frame_ipv6_o, frame_ipv4_o, frame_msg_o} =
    frame_end_o ? last : ~last;
endmodule

// *** testbench/tb_top.sv ***
module tb_top;
  import ptc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REF_DIV = 4;
  typedef struct packed {logic [31:0] c; logic [3:0] k; logic [3:0] m; logic e;} ptc_row_type;
  localparam ptc_row_type ROWS [26] = '{
    '{32'h2401, 4'h9, 4'h0, 1'b1}, '{32'h2401, 4'h9, 4'h8, 1'b1},
    '{32'h2401, 4'h9, 4'h3, 1'b0}, '{32'h2401, 4'h9, 4'hb, 1'b0},
    '{32'h6401, 4'h9, 4'h0, 1'b1}, '{32'h6401, 4'h9, 4'h1, 1'b0},
    '{32'he401, 4'h9, 4'h1, 1'b1}, '{32'he401, 4'h9, 4'h0, 1'b0},
    '{32'h1_2401, 4'h9, 4'ha, 1'b1}, '{32'h1_6401, 4'h9, 4'h3, 1'b1},
    '{32'h1_6401, 4'h9, 4'h8, 1'b0}, '{32'h1_e401, 4'h9, 4'h2, 1'b1},
    '{32'h1_e401, 4'h9, 4'h0, 1'b0}, '{32'h2_2401, 4'h9, 4'h1, 1'b1},
    '{32'h2_2401, 4'h9, 4'h8, 1'b0}, '{32'h3_2401, 4'h9, 4'h3, 1'b1},
    '{32'h3_2401, 4'h9, 4'h0, 1'b0}, '{32'h2401, 4'ha, 4'h0, 1'b0},
    '{32'h1401, 4'ha, 4'h0, 1'b1}, '{32'h2401, 4'hc, 4'h0, 1'b0},
    '{32'h2c01, 4'hc, 4'h0, 1'b1}, '{32'h2501, 4'h1, 4'hd, 1'b1},
    '{32'h2001, 4'h9, 4'h2, 1'b1}, '{32'h2001, 4'h9, 4'h8, 1'b0},
    '{32'h2500, 4'h9, 4'h0, 1'b0}, '{32'h2401, 4'h1, 4'h0, 1'b0}};

  logic        sys_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, update_subtract_i, send;
  logic        frame_end_i, frame_ptp_i, frame_ipv4_i, frame_ipv6_i, frame_raw_i;
  logic        snap_take_o, target_reached_o, stamping_enable_o;
  logic [15:0] reg_addr_i, update_hi_i, sys_time_hi_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, addend_value_i, target_sec_i, update_sec_i;
  logic [31:0] sys_time_sec_o, rd_v;
  logic [30:0] target_subsec_i, update_subsec_i, sys_time_subsec_o, t_sub;
  logic [3:0]  frame_msg_i, kind, msg;
  int          n_mismatch, checked;

  ptc_timestamp_control #(.REF_DIV(REF_DIV)) ptc_timestamp_control_i (.*);
  ptc_frame_src ptc_frame_src_i (.sys_clk_i, .sys_rst_i, .send_i(send), .kind_i(kind),
    .msg_i(msg), .frame_end_o(frame_end_i), .frame_ptp_o(frame_ptp_i),
    .frame_ipv4_o(frame_ipv4_i), .frame_ipv6_o(frame_ipv6_i), .frame_raw_o(frame_raw_i),
    .frame_msg_o(frame_msg_i));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [15:0] a);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    rd_v = reg_rdata_o;
    @(posedge sys_clk_i);
  endtask
  // Software polls up to eight reads for every command to read zero, then writes anyway
  task automatic cmd(input logic [31:0] d);
    for (int j = 0; j < 8; j++) begin
      rd(PTC_CTRL_OFFSET);
      if ((rd_v & 32'h0000_002c) == 32'h0) break;
    end
    chk(rd_v & 32'h0000_002c, 32'h0);
    wr(PTC_CTRL_OFFSET, d);
    @(negedge sys_clk_i);
  endtask
  task automatic frame(input logic [3:0] k, input logic [3:0] m, input logic e);
    send <= 1'b1;
    kind <= k;
    msg <= m;
    @(posedge sys_clk_i);
    send <= 1'b0;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk({31'h0, snap_take_o}, {31'h0, e});
    @(posedge sys_clk_i);
  endtask
  task automatic results();
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #40000;
    n_mismatch++;
    results();
  end
  initial begin
    {reg_wr_i, reg_rd_i, update_subtract_i, send, kind, msg} = '0;
    {reg_addr_i, reg_wdata_i, addend_value_i, target_sec_i, target_subsec_i} = '0;
    {update_hi_i, update_sec_i, update_subsec_i} = '0;
    n_mismatch = 0;
    checked = 0;
    sys_rst_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(PTC_CTRL_OFFSET);
    chk(rd_v, PTC_CTRL_RESET);
    rd(PTC_STEP_OFFSET);
    chk(rd_v, {24'h0, PTC_STEP_RESET});
    wr(PTC_CTRL_OFFSET, 32'hffff_ffc3);
    wr(PTC_STEP_OFFSET, 32'hffff_ffff);
    wr(16'h0708, 32'h0);
    rd(16'h0708);
    chk(rd_v, 32'h0);
    rd(PTC_CTRL_OFFSET);
    chk(rd_v, 32'h0003_ff03);
    rd(PTC_STEP_OFFSET);
    chk(rd_v, 32'h0000_00ff);
    foreach (ROWS[i]) begin
      wr(PTC_CTRL_OFFSET, ROWS[i].c);
      frame(ROWS[i].k, ROWS[i].m, ROWS[i].e);
    end
    wr(PTC_STEP_OFFSET, 32'h0);
    update_hi_i <= 16'h1234;
    update_sec_i <= 32'h0000_0005;
    update_subsec_i <= 31'h0000_0100;
    wr(PTC_CTRL_OFFSET, 32'h0000_0201);
    cmd(32'h0000_0205);
    chk({sys_time_hi_o, sys_time_sec_o[15:0]}, 32'h1234_0005);
    chk({1'b0, sys_time_subsec_o}, 32'h0000_0100);
    update_hi_i <= 16'haaaa;
    update_sec_i <= 32'h0000_0003;
    update_subsec_i <= 31'h0000_0010;
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk_i);
      update_subtract_i <= s[0];
      cmd(32'h0000_0209);
      chk({sys_time_hi_o, sys_time_sec_o[15:0]}, s ? 32'h1234_0005 : 32'h1234_0008);
      chk({1'b0, sys_time_subsec_o}, s ? 32'h0000_0100 : 32'h0000_0110);
    end
    @(posedge sys_clk_i);
    update_subtract_i <= 1'b0;
    wr(PTC_STEP_OFFSET, 32'h0000_0014);
    for (int m = 0; m < 2; m++) begin
      update_sec_i <= 32'h0000_0005;
      update_subsec_i <= (m == 0) ? PTC_DIGITAL_MAX - 31'h13 : PTC_BINARY_MAX - 31'h13;
      cmd((m == 0) ? 32'h0000_0205 : 32'h0000_0005);
      for (int j = 0; j < 20 && sys_time_subsec_o === update_subsec_i; j++) begin
        @(negedge sys_clk_i);
      end
      chk({1'b0, sys_time_subsec_o}, 32'h0);
      chk(sys_time_sec_o, 32'h0000_0006);
      @(posedge sys_clk_i);
    end
    @(negedge sys_clk_i);
    t_sub = sys_time_subsec_o;
    repeat (10 * REF_DIV) @(negedge sys_clk_i);
    chk({1'b0, sys_time_subsec_o - t_sub}, 32'h0000_00c8);
    rd_v = sys_time_sec_o;
    t_sub = sys_time_subsec_o + 31'h50;
    @(posedge sys_clk_i);
    target_sec_i <= rd_v;
    target_subsec_i <= t_sub;
    cmd(32'h0000_0011);
    for (int j = 0; j < 100 && target_reached_o !== 1'b1; j++) begin
      @(negedge sys_clk_i);
    end
    chk({31'h0, target_reached_o}, 32'h1);
    chk({31'h0, {sys_time_sec_o, sys_time_subsec_o} > {target_sec_i, target_subsec_i}},
        32'h1);
    @(posedge sys_clk_i);
    rd(PTC_CTRL_OFFSET);
    chk(rd_v, 32'h0000_0001);
    addend_value_i <= 32'h8000_0000;
    cmd(32'h0000_0023);
    @(posedge sys_clk_i);
    rd(PTC_CTRL_OFFSET);
    chk(rd_v, 32'h0000_0003);
    @(negedge sys_clk_i);
    t_sub = sys_time_subsec_o;
    repeat (20 * REF_DIV) @(negedge sys_clk_i);
    chk({1'b0, sys_time_subsec_o - t_sub}, 32'h0000_00c8);
    @(posedge sys_clk_i);
    wr(PTC_CTRL_OFFSET, 32'h0);
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    t_sub = sys_time_subsec_o;
    repeat (20) @(negedge sys_clk_i);
    chk({1'b0, sys_time_subsec_o}, {1'b0, t_sub});
    chk({31'h0, stamping_enable_o}, 32'h0);
    results();
  end
endmodule
